// file: hdl/mib_top.sv
/*
 * Maintenance I/O control register bank: control, address and status
 * latches with odd byte parity, data-out bytes, scan access path and the
 * shared maintenance I/O error latch, all reached over APB.
 * Assumes an APB master on pclk and synchronous inputs.
 */
// The implementer's own choices: the APB register port and the register offsets.
//
// Operation
// (R1) Mode B latches set, clear, read back
// (R2) Mode B holds defined value after reset
// (R3) Diagnostic mode written direct, read by scan
// (R4) Data, parity latch, error latch reported independently
// (R5) Branch trace latches writable, scannable, parity checked
// (R6) Address compare latches writable, scannable, parity checked
// (R7) Mode A latches writable, scannable, parity checked
// (R8) Local store address writable, scannable, checked
// (R9) Control store address bytes separately written, checked
// (R10) Status to unit: no parity latch fault
// (R11) Status E clear after reset, pattern writable
// (R12) Status D wait bit set by gates
// (R13) Status D clear after scan init, writable
// (R14) Status F scan loaded, direct readable
// (R15) Control lines decode gates one byte out
// (R16) Control latch patterns select returned byte
// (R17) Address decode returns only addressed byte
// (R18) Byte write updates one byte and parity
// (R19) Data-out parity error sets both latches
// (R20) Passing register leaves error latch clear
// (R21) Tester zeroes string select before checking
// (R22) Bypass bit blocks hard check stop
// (R23) Odd parity per byte
// (R24) One byte plus parity, reads non-destructive
module mib_top
    import mib_pkg::*;
#(
    parameter logic [7:0] MODE_B_INIT = MODE_B_RST
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic maint_io_error,
    output logic hard_check,
    output logic [7:0] mode_a,
    output logic [7:0] mode_b
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Odd parity bit for a byte
    function automatic logic odd_par(input logic [7:0] d);
        return ~(^d); // R23
    endfunction

    // True when a stored byte breaks odd parity
    function automatic logic par_bad(input mib_byte_t b);
        return ~(^{b.par, b.data}); // R23
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    mib_byte_t regs_ff [IDX_FIRST:IDX_LAST];
    logic [IDX_LAST:IDX_FIRST] lat_err_ff;
    logic maint_io_controller_err_ff;
    logic dout_par_err_ff;
    logic hard_ff;
    logic [3:0] scan_sel_ff;
    logic [3:0] dout_ctl_ff;
    logic [7:0] str_sel_ff;
    logic [3:0] gates_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    mib_state_t state_ff;
    mib_state_t nxt_state;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire logic [7:0] addr = paddr[7:0];
    wire logic [3:0] widx = paddr[5:2];
    wire logic access = psel && penable && (state_ff == MIB_IDLE);
    wire logic do_wr = access && pwrite;
    wire logic do_rd = access && !pwrite;
    wire logic hit_arr = (addr[1:0] == 2'b00) && (addr >= OFF_DOUT_X) && (addr <= OFF_STAT_F);
    wire logic hit_misc = (addr == OFF_DOUT_SEL) || (addr == OFF_SCAN_SEL) || (addr == OFF_SCAN_DATA)
        || (addr == OFF_DOUT_CTL) || (addr == OFF_STR_SEL) || (addr == OFF_ERR) || (addr == OFF_GATES);
    wire logic mapped = (paddr[31:8] == 24'h000000) && (hit_arr || hit_misc);
    wire logic wr_arr = do_wr && mapped && hit_arr;
    wire logic wr_scan = do_wr && mapped && (addr == OFF_SCAN_DATA);
    wire logic scan_ok = (scan_sel_ff != 4'h0);

    // ****************************************************************
    // Data-out byte selection
    // ****************************************************************
    // Direct address zero: the control latches pick the byte
    wire logic [2:0] ctl_code = dout_ctl_ff[3:1];
    wire logic sel_x = (ctl_code == SEL_BYTE_X); // R15
    wire logic sel_0 = (ctl_code == SEL_BYTE_0); // R16
    wire logic sel_1 = (ctl_code == SEL_BYTE_1); // R16
    wire mib_byte_t ctl_byte = sel_x ? regs_ff[IDX_DOUT_X] :
        sel_0 ? regs_ff[IDX_DOUT_0] :
        sel_1 ? regs_ff[IDX_DOUT_1] :
        mib_byte_t'({1'b1, 8'h00}); // R16
    // Direct byte address: the decoder drives the same lines
    wire logic rd_dsel = do_rd && (addr == OFF_DOUT_SEL);
    wire logic rd_dbyte = do_rd && (addr == OFF_DOUT_X || addr == OFF_DOUT_0 || addr == OFF_DOUT_1); // R17
    wire logic rd_dsel_live = rd_dsel && (sel_x || sel_0 || sel_1);
    wire mib_byte_t bus_byte = rd_dbyte ? regs_ff[widx] : ctl_byte; // R17
    wire logic dout_bad = (rd_dsel_live || rd_dbyte) && mapped && par_bad(bus_byte); // R19

    // ****************************************************************
    // Parity checking of stored latches
    // ****************************************************************
    logic [IDX_LAST:IDX_FIRST] bad_now;
    genvar gi;
    generate
        for (gi = IDX_FIRST; gi <= IDX_LAST; gi++)
        begin : g_chk
            if (gi == IDX_M2C_STAT)
            begin : g_nopar
                assign bad_now[gi] = 1'b0; // R10
            end
            else
            begin : g_par
                assign bad_now[gi] = par_bad(regs_ff[gi]); // R4
            end
        end
    endgenerate

    // Stored-latch parity errors reach the shared latch only with string select zero; data-out parity errors always do
    wire logic gate_open = (str_sel_ff == 8'h00); // R21
    wire logic maint_io_controller_set = (gate_open && (|bad_now)) || dout_bad; // R4 R19 R20
    wire logic wait_set = gates_ff[GATE_ENTRY_14] && gates_ff[GATE_ENTRY_15]
        && gates_ff[GATE_ENTRY_17] && gates_ff[GATE_MASK_17]; // R12
    wire logic bypass = regs_ff[IDX_DIAG_MODE].data[BIT_BYPASS];
    wire logic hard_set = maint_io_controller_err_ff && !bypass; // R22

    // ****************************************************************
    // Error clear (write one to clear; a same-cycle set wins)
    // ****************************************************************
    wire logic wr_err = do_wr && mapped && (addr == OFF_ERR);
    wire logic [IDX_LAST:IDX_FIRST] lat_clr = wr_err ? pwdata[ERR_LATCH_LSB +: IDX_LAST] : '0;
    wire logic maint_io_controller_clr = wr_err && pwdata[ERR_MAINT_IO_CONTROLLER];
    wire logic dout_clr = wr_err && pwdata[ERR_DOUT_PAR];
    wire logic hard_clr = wr_err && pwdata[ERR_HARD];

    // ****************************************************************
    // Read mux
    // ****************************************************************
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h00000000;
        if (hit_arr)
        begin
            rd_val = {23'h000000, regs_ff[widx]}; // R24
            if (widx == IDX_M2C_STAT)
            begin
                rd_val[BIT_PAR] = 1'b0; // R10
            end
        end
        else
        begin
            case (addr)
                OFF_DOUT_SEL: rd_val = {23'h000000, ctl_byte}; // R16
                OFF_SCAN_SEL: rd_val = {28'h0000000, scan_sel_ff};
                OFF_SCAN_DATA: rd_val = scan_ok ? {23'h000000, regs_ff[scan_sel_ff]} : 32'h00000000; // R3
                OFF_DOUT_CTL: rd_val = {28'h0000000, dout_ctl_ff};
                OFF_STR_SEL: rd_val = {24'h000000, str_sel_ff};
                OFF_ERR: rd_val = {1'b0, lat_err_ff, 13'h0000, hard_ff, dout_par_err_ff, maint_io_controller_err_ff}; // R4
                OFF_GATES: rd_val = {28'h0000000, gates_ff};
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Bus handshake: one wait state, answer from flip-flops
    // ****************************************************************
    always_comb
    begin
        case (state_ff)
            MIB_IDLE: nxt_state = access ? MIB_DONE : MIB_IDLE;
            MIB_DONE: nxt_state = MIB_IDLE;
            default: nxt_state = MIB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= MIB_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            pready_ff <= access;
            pslverr_ff <= access && !mapped;
            prdata_ff <= do_rd && mapped ? rd_val : 32'h00000000; // R24
        end
    end

    // ****************************************************************
    // Latch array: direct writes, scan loads and status set
    // ****************************************************************
    generate
        for (gi = IDX_FIRST; gi <= IDX_LAST; gi++)
        begin : g_reg
            wire logic dir_hit = wr_arr && (widx == 4'(gi));
            wire logic scan_hit = wr_scan && (scan_sel_ff == 4'(gi));
            mib_byte_t nxt_reg;
            always_comb
            begin
                nxt_reg = regs_ff[gi];
                if (scan_hit)
                begin
                    nxt_reg = mib_byte_t'(pwdata[8:0]); // R3 R13 R14
                end
                else if (dir_hit)
                begin
                    nxt_reg.data = pwdata[7:0]; // R1 R5 R6 R7 R8 R9 R10 R11 R13 R18
                    nxt_reg.par = odd_par(pwdata[7:0]); // R18 R23
                end
                if (gi == IDX_STAT_D && wait_set)
                begin
                    nxt_reg.data[BIT_WAIT_STATE] = 1'b1; // R12
                    nxt_reg.par = odd_par(nxt_reg.data);
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    if (gi == 4)
                    begin
                        regs_ff[gi] <= mib_byte_t'({odd_par(MODE_B_INIT), MODE_B_INIT}); // R2
                    end
                    else
                    begin
                        regs_ff[gi] <= mib_byte_t'({1'b1, 8'h00}); // R11 R13
                    end
                end
                else if (ce)
                begin
                    regs_ff[gi] <= nxt_reg;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Control, selection and error latches
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_sel_ff <= 4'h0;
            dout_ctl_ff <= 4'h0;
            str_sel_ff <= STR_SEL_RST;
            gates_ff <= 4'h0;
        end
        else if (ce && do_wr && mapped)
        begin
            if (addr == OFF_SCAN_SEL)
            begin
                scan_sel_ff <= pwdata[3:0];
            end
            if (addr == OFF_DOUT_CTL)
            begin
                dout_ctl_ff <= pwdata[3:0]; // R16
            end
            if (addr == OFF_STR_SEL)
            begin
                str_sel_ff <= pwdata[7:0]; // R21
            end
            if (addr == OFF_GATES)
            begin
                gates_ff <= pwdata[3:0]; // R12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat_err_ff <= '0;
            maint_io_controller_err_ff <= 1'b0;
            dout_par_err_ff <= 1'b0;
            hard_ff <= 1'b0;
        end
        else if (ce)
        begin
            lat_err_ff <= bad_now | (lat_err_ff & ~lat_clr); // R4
            maint_io_controller_err_ff <= maint_io_controller_set | (maint_io_controller_err_ff & !maint_io_controller_clr); // R4 R19 R20
            dout_par_err_ff <= dout_bad | (dout_par_err_ff & !dout_clr); // R19
            hard_ff <= hard_set | (hard_ff & !hard_clr); // R22
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign maint_io_error = maint_io_controller_err_ff;
    assign hard_check = hard_ff;
    assign mode_a = regs_ff[8].data;
    assign mode_b = regs_ff[4].data;

endmodule

// file: hdl/mib_pkg.sv
/*
 * Package of the maintenance I/O control register bank: register offsets,
 * field positions, reset values, byte carrier type and selection codes.
 * Assumes a 32-bit APB with byte addresses, one register per aligned word.
 */
package mib_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_DOUT_SEL = 8'h00;
    localparam logic [7:0] OFF_DOUT_X = 8'h04;
    localparam logic [7:0] OFF_DOUT_0 = 8'h08;
    localparam logic [7:0] OFF_DOUT_1 = 8'h0c;
    localparam logic [7:0] OFF_MODE_B = 8'h10;
    localparam logic [7:0] OFF_DIAG_MODE = 8'h14;
    localparam logic [7:0] OFF_BR_TRACE = 8'h18;
    localparam logic [7:0] OFF_ADDR_CMP = 8'h1c;
    localparam logic [7:0] OFF_MODE_A = 8'h20;
    localparam logic [7:0] OFF_LS_ADDR = 8'h24;
    localparam logic [7:0] OFF_CS_ADDR0 = 8'h28;
    localparam logic [7:0] OFF_CS_ADDR1 = 8'h2c;
    localparam logic [7:0] OFF_M2C_STAT = 8'h30;
    localparam logic [7:0] OFF_STAT_E = 8'h34;
    localparam logic [7:0] OFF_STAT_D = 8'h38;
    localparam logic [7:0] OFF_STAT_F = 8'h3c;
    localparam logic [7:0] OFF_SCAN_SEL = 8'h40;
    localparam logic [7:0] OFF_SCAN_DATA = 8'h44;
    localparam logic [7:0] OFF_DOUT_CTL = 8'h48;
    localparam logic [7:0] OFF_STR_SEL = 8'h4c;
    localparam logic [7:0] OFF_ERR = 8'h50;
    localparam logic [7:0] OFF_GATES = 8'h54;

    // ****************************************************************
    // Latch array indices (word index of the register)
    // ****************************************************************
    localparam int IDX_FIRST = 1;
    localparam int IDX_LAST = 15;
    localparam logic [3:0] IDX_DOUT_X = 4'h1;
    localparam logic [3:0] IDX_DOUT_0 = 4'h2;
    localparam logic [3:0] IDX_DOUT_1 = 4'h3;
    localparam logic [3:0] IDX_DIAG_MODE = 4'h5;
    localparam logic [3:0] IDX_M2C_STAT = 4'hc;
    localparam logic [3:0] IDX_STAT_D = 4'he;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_PAR = 8;
    localparam int BIT_BYPASS = 0;
    localparam int BIT_WAIT_STATE = 6;
    localparam int ERR_MAINT_IO_CONTROLLER = 0;
    localparam int ERR_DOUT_PAR = 1;
    localparam int ERR_HARD = 2;
    localparam int ERR_LATCH_LSB = 16;
    localparam int GATE_ENTRY_14 = 0;
    localparam int GATE_ENTRY_15 = 1;
    localparam int GATE_ENTRY_17 = 2;
    localparam int GATE_MASK_17 = 3;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [7:0] MODE_B_RST = 8'h00;
    localparam logic [7:0] STR_SEL_RST = 8'hff;
    localparam logic [2:0] SEL_BYTE_X = 3'h4;
    localparam logic [2:0] SEL_BYTE_0 = 3'h2;
    localparam logic [2:0] SEL_BYTE_1 = 3'h1;

    // One maintenance byte with its parity latch
    typedef struct packed {
        logic par;
        logic [7:0] data;
    } mib_byte_t;

    typedef enum logic [1:0] {
        MIB_IDLE = 2'b01,
        MIB_DONE = 2'b10
    } mib_state_t;

endpackage

// file: bench/mib_apb_master.sv
/*
 * Maintenance processor model: APB master issuing one word per transfer.
 * Assumes pclk from the bench and a slave answering with pready.
 */
module mib_apb_master
(
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    output logic tmo
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        tmo = 1'b0;
    end

    // One 32-bit word per transfer, held until pready or for at most 20 cycles
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            tmo = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse, not the last value
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// file: bench/mib_assertions.sv
/*
 * Port checker of the register bank.
 * Assumes it is bound to mib_top and sees only its ports.
 */
module mib_assertions
    import mib_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic maint_io_error,
    input wire logic hard_check,
    input wire logic [7:0] mode_a,
    input wire logic [7:0] mode_b
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire acc = psel && penable && !pready && ce;

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");
    property p_ready_next;
        acc |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("pready missing after access");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("pready outside access phase");
    property p_refuse;
        pready && (paddr[31:8] != 24'h0 || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("unmapped access not refused");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");

    // ****************************************************************
    // Latches
    // ****************************************************************
    property p_mode_b_wr;
        acc && pwrite && paddr == {24'h0, OFF_MODE_B} |=> mode_b == $past(pwdata[7:0]);
    endproperty
    a_mode_b_wr: assert property (p_mode_b_wr)
        else $error("mode_b not loaded by write");
    property p_mode_a_wr;
        acc && pwrite && paddr == {24'h0, OFF_MODE_A} |=> mode_a == $past(pwdata[7:0]);
    endproperty
    a_mode_a_wr: assert property (p_mode_a_wr)
        else $error("mode_a not loaded by write");
    property p_mode_b_hold;
        !$stable(mode_b) |-> $past(psel && pwrite && (paddr == {24'h0, OFF_MODE_B} ||
            paddr == {24'h0, OFF_SCAN_DATA}));
    endproperty
    a_mode_b_hold: assert property (p_mode_b_hold)
        else $error("mode_b changed without write");
    property p_err_clear;
        $fell(maint_io_error) |-> $past(psel && penable && pwrite && paddr == {24'h0, OFF_ERR});
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error latch cleared without write");
    property p_hard_cause;
        $rose(hard_check) |-> $past(maint_io_error);
    endproperty
    a_hard_cause: assert property (p_hard_cause)
        else $error("hard check without error latch");

    c_refused: cover property (pready && pslverr);
    c_err: cover property ($rose(maint_io_error));
    c_hard: cover property ($rose(hard_check));
endmodule

bind mib_top mib_assertions i_mib_assertions (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .maint_io_error(maint_io_error), .hard_check(hard_check), .mode_a(mode_a),
    .mode_b(mode_b));

// file: bench/tb_maint_io_ctrl_register_bank.sv
/*
 * Self-checking bench of the register bank: driver notes results, monitor compares.
 * Assumes mib_top, the APB master model and the bound checker.
 */
module tb_maint_io_ctrl_register_bank
    import mib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic chk; logic err; logic [31:0] val; logic [31:0] msk;} mib_exp_t;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, maint_io_error, hard_check, tmo;
    logic [31:0] paddr, pwdata, prdata;
    logic [7:0] mode_a, mode_b, v;
    mib_exp_t expq[$];
    mib_exp_t e;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 45;
    logic [7:0] offs [11] = '{OFF_MODE_B, OFF_DIAG_MODE, OFF_BR_TRACE, OFF_ADDR_CMP, OFF_MODE_A,
        OFF_LS_ADDR, OFF_CS_ADDR0, OFF_CS_ADDR1, OFF_STAT_E, OFF_STAT_D, OFF_STAT_F};
    logic [31:0] bad [3] = '{32'h100, 32'h58, 32'h11};

    mib_top i_mib_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .maint_io_error(maint_io_error), .hard_check(hard_check), .mode_a(mode_a),
        .mode_b(mode_b));
    mib_apb_master i_mib_apb_master (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tmo(tmo));

    function automatic logic [31:0] wd(input logic [7:0] x);
        return {23'h0, ~^x, x};
    endfunction

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input mib_exp_t x);
        expq.push_back(x);
        i_mib_apb_master.xfer(w, a, d);
        if (tmo === 1'b1)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        bus(1'b1, {24'h0, o}, d, '{1'b0, 1'b0, 32'h0, 32'h0});
    endtask

    task automatic rd(input logic [7:0] o, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
        bus(1'b0, {24'h0, o}, 32'h0, '{1'b1, 1'b0, x, m});
    endtask

    // Monitor takes the oldest note at each answer
    always @(posedge pclk)
    begin
        if (pready === 1'b1)
        begin
            if (expq.size() == 0)
                cmp("answer count", 32'h0, 32'h1);
            else
            begin
                e = expq.pop_front();
                cmp("pslverr", {31'h0, e.err}, {31'h0, pslverr});
                if (e.chk)
                    cmp("prdata", e.val, prdata & e.msk);
            end
        end
    end

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cmp("mode_b", {24'h0, MODE_B_RST}, {24'h0, mode_b});
        rd(OFF_MODE_B, wd(MODE_B_RST));
        rd(OFF_STAT_E, wd(8'h00));
        rd(OFF_STAT_D, wd(8'h00));
        wr(OFF_STR_SEL, 32'h0);
        for (int i = 0; i < 11; i++)
            for (int k = 0; k < 3; k++)
            begin
                v = (k == 0) ? 8'h55 : (k == 1) ? 8'haa : 8'($random(seed));
                wr(offs[i], {24'h0, v});
                rd(offs[i], wd(v));
                if (offs[i] == OFF_MODE_A)
                    cmp("mode_a", {24'h0, v}, {24'h0, mode_a});
                wr(OFF_SCAN_SEL, {24'h0, offs[i] >> 2});
                rd(OFF_SCAN_DATA, wd(v));
            end
        rd(OFF_ERR, 32'h0);
        cmp("maint_io_error", 32'h0, {31'h0, maint_io_error});
        wr(OFF_M2C_STAT, 32'ha5);
        rd(OFF_M2C_STAT, 32'ha5);
        wr(OFF_SCAN_SEL, {28'h0, IDX_M2C_STAT});
        wr(OFF_SCAN_DATA, 32'h0);
        rd(OFF_ERR, 32'h0);
        wr(OFF_SCAN_SEL, 32'hf);
        wr(OFF_SCAN_DATA, wd(8'h3c));
        rd(OFF_STAT_F, wd(8'h3c));
        for (int b = 0; b < 2; b++)
        begin
            wr(OFF_DIAG_MODE, b);
            wr(OFF_SCAN_SEL, 32'h9);
            wr(OFF_SCAN_DATA, 32'h0);
            rd(OFF_LS_ADDR, 32'h0);
            rd(OFF_ERR, b ? 32'h01000001 : 32'h01000005);
            cmp("hard_check", b ? 32'h0 : 32'h1, {31'h0, hard_check});
            wr(OFF_LS_ADDR, 32'h0);
            // With the bypass bit clear, hard check re-arms at the first clear while the error latch still stands
            wr(OFF_ERR, 32'hffffffff);
            wr(OFF_ERR, 32'hffffffff);
            rd(OFF_ERR, 32'h0);
        end
        for (int j = 0; j < 3; j++)
            wr(OFF_DOUT_X + 8'(4 * j), 32'h0);
        for (int b = 0; b < 3; b++)
        begin
            wr(OFF_DOUT_X + 8'(4 * b), 32'hff);
            for (int j = 0; j < 3; j++)
                rd(OFF_DOUT_X + 8'(4 * j), wd((j == b) ? 8'hff : 8'h00));
            for (int c = 0; c < 4; c++)
            begin
                wr(OFF_DOUT_CTL, 32'h8 >> c);
                rd(OFF_DOUT_SEL, wd((c == b) ? 8'hff : 8'h00));
            end
            wr(OFF_DOUT_X + 8'(4 * b), 32'h0);
        end
        wr(OFF_STR_SEL, 32'hff);
        wr(OFF_SCAN_SEL, {28'h0, IDX_DOUT_0});
        wr(OFF_SCAN_DATA, 32'h0);
        rd(OFF_DOUT_0, 32'h0);
        rd(OFF_ERR, 32'h3, 32'h3);
        cmp("maint_io_error", 32'h1, {31'h0, maint_io_error});
        ce <= 1'b0;
        fork
            begin
                repeat (6) @(posedge pclk);
                ce <= 1'b1;
            end
        join_none
        wr(OFF_DIAG_MODE, 32'h0);
        rd(OFF_ERR, 32'h5, 32'h5);
        wr(OFF_STAT_D, 32'h0);
        wr(OFF_GATES, 32'h7);
        rd(OFF_STAT_D, wd(8'h00));
        wr(OFF_GATES, 32'hf);
        rd(OFF_STAT_D, wd(8'h40));
        for (int j = 0; j < 3; j++)
            bus(1'b0, bad[j], 32'h0, '{1'b1, 1'b1, 32'h0, 32'hffffffff});
        end_sim();
    end
endmodule
